/* core/sarc_pkg.sv */
// SAR converter control package: register map, field layout, timing counts.
// Assumes a 200 MHz APB clock and a converter core that answers per bit.
package sarc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SARC_OFS_CSR = 8'h00;
  localparam logic [7:0] SARC_OFS_HIGH = 8'h04;
  localparam logic [7:0] SARC_OFS_LOW = 8'h08;
  localparam logic [7:0] SARC_OFS_SYS = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int SARC_EOC_BIT = 7;
  localparam int SARC_DIV_LSB = 5;
  localparam int SARC_ON_BIT = 4;
  localparam int SARC_IRQEN_BIT = 0;
  localparam int SARC_HALT_BIT = 1;
  localparam int SARC_WAIT_BIT = 2;
  localparam logic [7:0] SARC_CSR_RESET = 8'h00;
  localparam logic [9:0] SARC_RESULT_RESET = 10'h000;

  // ----------------------------------------------------------------
  // Timing: pclk cycles per converter clock period
  // ----------------------------------------------------------------
  localparam int SARC_PCLK_MHZ = 200;
  localparam int SARC_FADC0_MHZ = 4;
  localparam int SARC_FADC1_MHZ = 2;
  localparam int SARC_FADC2_MHZ = 1;
  localparam logic [7:0] SARC_DIV0 = 8'(SARC_PCLK_MHZ / SARC_FADC0_MHZ);
  localparam logic [7:0] SARC_DIV1 = 8'(SARC_PCLK_MHZ / SARC_FADC1_MHZ);
  localparam logic [7:0] SARC_DIV2 = 8'(SARC_PCLK_MHZ / SARC_FADC2_MHZ);
  localparam int SARC_BITS = 10;
  localparam logic [3:0] SARC_SAMPLE_TICKS = 4'h3;

  typedef enum logic [2:0]
  {
    SARC_ST_OFF = 3'b001,
    SARC_ST_SAMPLE = 3'b010,
    SARC_ST_CONVERT = 3'b100
  } sarc_state_type;

  typedef struct packed
  {
    logic [1:0] clock_divider_sel;
    logic converter_power_on;
    logic [3:0] channel;
  } sarc_ctrl_type;

endpackage

/* core/sarc_unit.sv */
// SAR converter control unit: APB registers, divider, SAR sequencer, result lock.
// Assumes a comparator core: sarc_cmp_in says analog input >= trial code.
//
// Function
// - Power-on bit starts converting selected channel
// - Converts continuously while power-on bit set
// - End flag stays set until high read or abort
// - Channel change aborts and restarts conversion
// - Completion sets read-only end flag
// - Irq only when enable set; wakes wait
// - Result stays until next conversion ends
// - High result read clears end flag
// - Low result read locks both registers
// - Lock released by high read or off
// - Locked registers ignore completed results
// - Over upper reference gives full scale
// - Under lower reference gives zero
// - Divider select gives 4, 2, 1 MHz
// - Channel field routes input n
// - High register holds result bits 9:2
// - Low register holds bits 1:0, zeros above
// - Clearing power-on stops conversion
// - Wait mode leaves conversion unaffected
// - Halt mode disables the converter
`timescale 1ns/10ps
module sarc_unit
  import sarc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core
  output logic [3:0] sarc_channel,
  output logic sarc_power,
  output logic sarc_sample,
  output logic [9:0] sarc_trial,
  input wire logic sarc_cmp_in,
  // System
  input wire logic sarc_halt_in,
  output logic sarc_irq
);
  import sarc_pkg::*;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_csr = paddr == SARC_OFS_CSR;
  wire hit_high = paddr == SARC_OFS_HIGH;
  wire hit_low = paddr == SARC_OFS_LOW;
  wire hit_sys = paddr == SARC_OFS_SYS;
  wire mapped = hit_csr || hit_high || hit_low || hit_sys;
  wire rd_high = rd && hit_high;
  wire rd_low = rd && hit_low;
  // A low read in setup or access freezes the result, so its latched low bits
  // pair with the high byte that the lock then keeps
  wire low_pend = psel && !pwrite && hit_low;

  sarc_ctrl_type ctrl_q;
  logic eoc_q;
  logic lock_q;
  logic irq_en_q;
  logic [9:0] result_q;
  sarc_state_type state_q;
  logic [9:0] sar_q;
  logic [3:0] bit_q;
  logic [3:0] tick_q;
  logic [7:0] div_q;

  wire csr_wr = wr && hit_csr;
  wire [3:0] new_chan = pwdata[3:0];
  wire chan_change = csr_wr && (new_chan != ctrl_q.channel);
  wire enabled = ctrl_q.converter_power_on && !sarc_halt_in;
  // Restart also realigns the divider, so every conversion gets its full sample time
  wire restart = chan_change || (csr_wr && !ctrl_q.converter_power_on && pwdata[SARC_ON_BIT]);

  // ----------------------------------------------------------------
  // Converter clock tick
  // ----------------------------------------------------------------
  function automatic logic [7:0] tick_period(input logic [1:0] sel);
    case (sel)
      2'b00: tick_period = SARC_DIV0;
      2'b01: tick_period = SARC_DIV1;
      default: tick_period = SARC_DIV2;
    endcase
  endfunction

  wire [7:0] div_top = tick_period(ctrl_q.clock_divider_sel) - 8'h01;
  wire tick = div_q >= div_top;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= 8'h00;
    else if (!enabled || tick || restart)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end

  // ----------------------------------------------------------------
  // Successive approximation sequencer
  // ----------------------------------------------------------------
  wire last_bit = bit_q == 4'h0;
  wire done = (state_q == SARC_ST_CONVERT) && tick && last_bit && enabled && !restart;
  wire [9:0] bit_mask = 10'(10'h001 << bit_q);
  // Comparator decides the trial bit; a high input keeps it set, low clears it
  wire [9:0] sar_keep = sarc_cmp_in ? sar_q : (sar_q & ~bit_mask);
  wire [9:0] sar_next = last_bit ? sar_keep : (sar_keep | (bit_mask >> 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= SARC_ST_OFF;
      sar_q <= 10'h000;
      bit_q <= 4'h0;
      tick_q <= 4'h0;
    end
    else if (!enabled)
    begin
      state_q <= SARC_ST_OFF;
      tick_q <= 4'h0;
    end
    else if (restart)
    begin
      state_q <= SARC_ST_SAMPLE;
      tick_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        SARC_ST_OFF:
        begin
          state_q <= SARC_ST_SAMPLE;
          tick_q <= 4'h0;
        end
        SARC_ST_SAMPLE:
          if (tick)
          begin
            tick_q <= tick_q + 4'h1;
            if (tick_q == SARC_SAMPLE_TICKS)
            begin
              state_q <= SARC_ST_CONVERT;
              bit_q <= 4'(SARC_BITS - 1);
              sar_q <= 10'h200;
            end
          end
        SARC_ST_CONVERT:
          if (tick)
          begin
            sar_q <= sar_next;
            if (last_bit)
            begin
              state_q <= SARC_ST_SAMPLE;
              tick_q <= 4'h0;
            end
            else
              bit_q <= bit_q - 4'h1;
          end
        default:
          state_q <= SARC_ST_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control, flag, lock and result registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= sarc_ctrl_type'(7'h00);
      irq_en_q <= 1'b0;
    end
    else if (csr_wr)
      ctrl_q <= {pwdata[6:5], pwdata[SARC_ON_BIT], pwdata[3:0]};
    else if (wr && hit_sys)
      irq_en_q <= pwdata[SARC_IRQEN_BIT];
  end

  wire in_conv = state_q != SARC_ST_OFF;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eoc_q <= 1'b0;
    else if (done)
      eoc_q <= 1'b1; // set wins over read clear
    else if (rd_high || (restart && in_conv))
      eoc_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lock_q <= 1'b0;
    else if (rd_high || !ctrl_q.converter_power_on)
      lock_q <= 1'b0;
    else if (rd_low)
      lock_q <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_q <= SARC_RESULT_RESET;
    else if (done && !lock_q && !low_pend)
      result_q <= sar_keep;
  end

  // ----------------------------------------------------------------
  // Read data and outputs
  // ----------------------------------------------------------------
  wire [7:0] csr_rd = {eoc_q, ctrl_q.clock_divider_sel, ctrl_q.converter_power_on,
    ctrl_q.channel};
  wire [7:0] high_rd = result_q[9:2];
  wire [7:0] low_rd = {6'h00, result_q[1:0]};
  wire [7:0] sys_rd = {5'h00, 1'b0, sarc_halt_in, irq_en_q};
  wire [7:0] rd_mux = hit_csr ? csr_rd : hit_high ? high_rd : hit_low ? low_rd :
    hit_sys ? sys_rd : 8'h00;
  // Latched in the setup cycle so the word stands through the whole access phase

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= {24'h00_0000, rd_mux};
  end

  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign sarc_channel = ctrl_q.channel;
  assign sarc_power = enabled;
  assign sarc_sample = state_q == SARC_ST_SAMPLE;
  assign sarc_trial = sar_q;
  assign sarc_irq = eoc_q && irq_en_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_irq_on_done;
    @(posedge pclk) disable iff (!presetn) (done && irq_en_q && !(wr && hit_sys)) |=> sarc_irq;
  endproperty
  a_irq_on_done: assert property (p_irq_on_done) else $error("no irq on done");

  property p_eoc_on_done;
    @(posedge pclk) disable iff (!presetn) done |=> eoc_q;
  endproperty
  a_eoc_on_done: assert property (p_eoc_on_done) else $error("flag not set");

  property p_high_clears;
    @(posedge pclk) disable iff (!presetn) (rd_high && !done) |=> !eoc_q;
  endproperty
  a_high_clears: assert property (p_high_clears) else $error("high read kept flag");

  property p_lock_holds;
    @(posedge pclk) disable iff (!presetn) lock_q |=> $stable(result_q);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked result changed");

  property p_low_locks;
    @(posedge pclk) disable iff (!presetn)
      (rd_low && ctrl_q.converter_power_on && !csr_wr) |=> lock_q;
  endproperty
  a_low_locks: assert property (p_low_locks) else $error("low read no lock");

  property p_unlock;
    @(posedge pclk) disable iff (!presetn) (rd_high || !ctrl_q.converter_power_on) |=> !lock_q;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock not released");

  property p_off_stops;
    @(posedge pclk) disable iff (!presetn) !enabled |=> state_q == SARC_ST_OFF;
  endproperty
  a_off_stops: assert property (p_off_stops) else $error("converter running while off");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      (state_q == SARC_ST_OFF && enabled) |=> state_q == SARC_ST_SAMPLE;
  endproperty
  a_start: assert property (p_start) else $error("no start after enable");

  property p_chan_abort;
    @(posedge pclk) disable iff (!presetn) (chan_change && enabled && pwdata[SARC_ON_BIT])
      |=> state_q == SARC_ST_SAMPLE && sarc_channel == $past(new_chan);
  endproperty
  a_chan_abort: assert property (p_chan_abort) else $error("channel change not restarted");

  property p_result_stable;
    @(posedge pclk) disable iff (!presetn) !done |=> $stable(result_q);
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("result changed early");

  property p_restart_clears;
    @(posedge pclk) disable iff (!presetn)
      (restart && in_conv) |=> !eoc_q;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("flag kept");

  property p_repeat;
    @(posedge pclk) disable iff (!presetn)
      done |=> state_q == SARC_ST_SAMPLE;
  endproperty
  a_repeat: assert property (p_repeat) else $error("no new conversion");

  property p_bit_kept;
    @(posedge pclk) disable iff (!presetn)
      (state_q == SARC_ST_CONVERT && tick && enabled && !restart && sarc_cmp_in)
      |=> (sar_q & $past(bit_mask)) == $past(bit_mask);
  endproperty
  a_bit_kept: assert property (p_bit_kept) else $error("trial bit lost");

  property p_bit_dropped;
    @(posedge pclk) disable iff (!presetn)
      (state_q == SARC_ST_CONVERT && tick && enabled && !restart && !sarc_cmp_in)
      |=> (sar_q & $past(bit_mask)) == 10'h000;
  endproperty
  a_bit_dropped: assert property (p_bit_dropped) else $error("trial bit kept");

  property p_chan_follow;
    @(posedge pclk) disable iff (!presetn)
      csr_wr |=> sarc_channel == $past(new_chan);
  endproperty
  a_chan_follow: assert property (p_chan_follow) else $error("channel not routed");

  property p_rd_high_map;
    @(posedge pclk) disable iff (!presetn) (psel && !penable && !pwrite && hit_high)
      |=> prdata == {24'h00_0000, $past(result_q[9:2])};
  endproperty
  a_rd_high_map: assert property (p_rd_high_map) else $error("high byte wrong");

  property p_rd_low_map;
    @(posedge pclk) disable iff (!presetn) (psel && !penable && !pwrite && hit_low)
      |=> prdata == {30'h0, $past(result_q[1:0])};
  endproperty
  a_rd_low_map: assert property (p_rd_low_map) else $error("low bits wrong");

  property p_halt_stops;
    @(posedge pclk) disable iff (!presetn)
      sarc_halt_in |=> state_q == SARC_ST_OFF;
  endproperty
  a_halt_stops: assert property (p_halt_stops) else $error("running in halt");

  property p_low_pending;
    @(posedge pclk) disable iff (!presetn)
      low_pend |=> $stable(result_q);
  endproperty
  a_low_pending: assert property (p_low_pending) else $error("result moved");

  property p_result_load;
    @(posedge pclk) disable iff (!presetn)
      (done && !lock_q && !low_pend) |=> result_q == $past(sar_keep);
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_done: cover property (@(posedge pclk) disable iff (!presetn) done);
  c_halt: cover property (@(posedge pclk) disable iff (!presetn) sarc_halt_in && enabled);
  c_locked_done: cover property (@(posedge pclk) disable iff (!presetn) done && lock_q);
  c_abort: cover property (@(posedge pclk) disable iff (!presetn) chan_change && in_conv);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) sarc_irq);

endmodule

/* verif/sarc_core_model.sv */
// Converter core model: per-channel analog levels, sample and hold, comparator.
// Assumes levels are in codes; above 1023 is over the upper reference, below 0 under.
`timescale 1ns/10ps
module sarc_core_model
(
  // Converter side
  input wire logic pclk,
  input wire logic [3:0] sarc_channel,
  input wire logic sarc_power,
  input wire logic sarc_sample,
  input wire logic [9:0] sarc_trial,
  // Analog levels
  input int lvl [16],
  output logic sarc_cmp_in
);
  int held;
  logic junk = 1'b0;
  // ----------------------------------------------------------------
  // Sample and hold
  // ----------------------------------------------------------------
  // Sources are low impedance, so the fixed sample time needs no stretch
  always @(posedge pclk)
  begin
    junk <= ~junk;
    if (sarc_sample)
      held <= lvl[sarc_channel];
  end
  // Unpowered comparator gives noise, not a stale answer
  assign sarc_cmp_in = sarc_power ? (held >= int'(sarc_trial)) : junk;
endmodule

/* verif/tb.sv */
// Testbench: APB master, converter model, result checks against a level model.
// Assumes zero-wait APB slave and 14 converter ticks per conversion.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("Error t=%0t got %0h exp %0h", $time, a, b); end end
module tb;
  import sarc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sarc_halt_in, er, irq_d;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, sarc_power, sarc_sample, sarc_cmp_in, sarc_irq;
  wire logic [3:0] sarc_channel;
  wire logic [9:0] sarc_trial;
  int lv [16];
  int rises[$];
  int miscompares, samples_checked, cyc, w, n;
  sarc_unit i_sarc_unit(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sarc_channel, .sarc_power, .sarc_sample, .sarc_trial,
    .sarc_cmp_in, .sarc_halt_in, .sarc_irq);
  sarc_core_model i_sarc_core_model(.pclk, .sarc_channel, .sarc_power, .sarc_sample,
    .sarc_trial, .lvl(lv), .sarc_cmp_in);
  // ----------------------------------------------------------------
  // Clock, cycle count, completion times, timeout
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    irq_d <= sarc_irq;
    if (sarc_irq === 1'b1 && irq_d !== 1'b1)
      rises.push_back(cyc);
    if (cyc > 50000)
    begin
      miscompares++;
      stop_test;
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_irq;
    int k;
    k = 0;
    while (sarc_irq !== 1'b1 && k < 3500)
    begin
      @(posedge pclk);
      k++;
    end
    @(posedge pclk);
    `CHK(sarc_irq, 1'b1)
  endtask
  function automatic logic [31:0] csr(int d, int on, int ch);
    return 32'((d << SARC_DIV_LSB) | (on << SARC_ON_BIT) | ch);
  endfunction
  function automatic logic [9:0] exp_res(int l);
    return (l > 1023) ? 10'h3FF : (l < 0) ? 10'h000 : 10'(l);
  endfunction
  task automatic rd_res(input int l);
    logic [9:0] e;
    e = exp_res(l);
    apb(1'b0, SARC_OFS_LOW, 32'h0);
    `CHK(rd, {30'h0, e[1:0]})
    apb(1'b0, SARC_OFS_HIGH, 32'h0);
    `CHK(rd, {24'h0, e[9:2]})
  endtask
  task automatic conv(input int ch, input int l);
    lv[ch] <= l;
    apb(1'b1, SARC_OFS_CSR, csr(0, 1, ch));
    w = cyc;
    `CHK(sarc_channel, 4'(ch))
    `CHK(sarc_power, 1'b1)
    wait_irq;
    `CHK((rises[$] - w) inside {[650:710]}, 1'b1)
    rd_res(l);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, sarc_halt_in} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lv = '{default: 0};
    void'($urandom(32'h8C4A));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 16; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0);
      `CHK(rd, 32'h0)
    end
    apb(1'b0, 8'h10, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, SARC_OFS_SYS, 32'h1);
    for (int i = 0; i < 16; i++)
      conv(i, (i == 7) ? 5000 : (i == 8) ? -5 : $urandom_range(0, 1023));
    for (int d = 0; d < 4; d++)
    begin
      apb(1'b1, SARC_OFS_CSR, csr(d, 1, 1));
      wait_irq;
      apb(1'b0, SARC_OFS_HIGH, 32'h0);
      apb(1'b0, SARC_OFS_CSR, 32'h0);
      `CHK(rd[SARC_EOC_BIT], 1'b0)
      wait_irq;
      `CHK(rises[$] - rises[$-1], 14 * SARC_PCLK_MHZ / ((d == 0) ? 4 : (d == 1) ? 2 : 1))
    end
    conv(3, 301);
    wait_irq;
    apb(1'b0, SARC_OFS_LOW, 32'h0);
    lv[3] <= 700;
    repeat (1600) @(posedge pclk);
    apb(1'b0, SARC_OFS_HIGH, 32'h0);
    `CHK(rd, 32'h4B)
    wait_irq;
    rd_res(700);
    apb(1'b1, SARC_OFS_SYS, 32'h0);
    repeat (750) @(posedge pclk);
    apb(1'b0, SARC_OFS_CSR, 32'h0);
    `CHK({rd[SARC_EOC_BIT], sarc_irq}, 2'b10)
    apb(1'b1, SARC_OFS_SYS, 32'h1);
    `CHK(sarc_irq, 1'b1)
    apb(1'b0, SARC_OFS_LOW, 32'h0);
    apb(1'b1, SARC_OFS_CSR, csr(0, 0, 2));
    n = rises.size();
    `CHK(sarc_power, 1'b0)
    apb(1'b1, SARC_OFS_SYS, 32'h0);
    apb(1'b1, SARC_OFS_SYS, 32'h1);
    repeat (800) @(posedge pclk);
    `CHK(rises.size(), n)
    conv(2, 900);
    sarc_halt_in <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(sarc_power, 1'b0)
    sarc_halt_in <= 1'b0;
    stop_test;
  end
endmodule
